// [rtl/osc_ctrl_map.vh]
// Register indices, field positions, reset values and bus codes of the oscillator control bank.
`ifndef OSC_CTRL_MAP_VH
`define OSC_CTRL_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define OSC_IDX_DEVICE_CONTROL 10'h00A
`define OSC_IDX_MARGIN_HI 10'h010
`define OSC_IDX_MARGIN_LO 10'h011
`define OSC_IDX_OUT_CTL 10'h014
`define OSC_IDX_OUT_POL 10'h015
`define OSC_IDX_STATUS 10'h042
`define OSC_IDX_SW_RST 10'h048

// Field positions in device_control.
`define OSC_DC_PDN 6
`define OSC_DC_SEL 5
`define OSC_DC_CAL 1
`define OSC_DC_AUTO 0

// Field positions in output_control and output_polarity.
`define OSC_OC_HIZ 2
`define OSC_OC_MUTE 1
`define OSC_OP_INV1 5
`define OSC_OP_INV0 4

// Field position of the software reset bit.
`define OSC_SR_BIT 0

// Field positions in the status register.
`define OSC_ST_PLL_EN 0
`define OSC_ST_CAL_BUSY 1
`define OSC_ST_LOCKED 2
`define OSC_ST_OUT_EN 3
`define OSC_ST_HALTED 4

// Reset values.
`define OSC_RST_PDN 1'b0
`define OSC_RST_SEL 1'b1
`define OSC_RST_CAL 1'b0
`define OSC_RST_AUTO 1'b1
`define OSC_RST_MARGIN_HI 2'h0
`define OSC_RST_MARGIN_LO 8'h80
`define OSC_RST_HIZ 1'b0
`define OSC_RST_MUTE 1'b0
`define OSC_RST_INV 1'b0

// AXI response codes.
`define OSC_RESP_OKAY 2'h0
`define OSC_RESP_SLVERR 2'h2

`endif

// [rtl/osc_ctrl_regs.v]
// AXI4-Lite register bank of the programmable oscillator with its lock sequencer.
//
// How it works
// R1: Power-down bit disables PLL, resets calibration.
// R2: Clearing power-down re-enables PLL and recalibrates.
// R3: Hardware reset enables and calibrates PLL automatically.
// R4: Trigger bit rising starts calibration of the PLL.
// R5: Trigger bit clears itself when calibration completes.
// R6: Auto-start outranks trigger during reset start-up.
// R7: Auto-start set: lock then enable outputs.
// R8: Power-on, reset pin, software bit reset device.
// R9: Auto-start clear halts; writing one starts lock.
// R10: Ten-bit margin offset formed from two registers.
// R11: Tri-state bit floats first output.
// R12: Mute bit silences the clock output.
// R13: Polarity bits five, four invert outputs.
// R14: Reserved bits read zero, writes ignored.
`include "osc_ctrl_map.vh"

module osc_ctrl_regs #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  input wire reset_input_pin_n_i,
  // AXI4-Lite write address channel
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire [2:0] s_axi_awprot_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // AXI4-Lite write data channel
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // AXI4-Lite write response channel
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address channel
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire [2:0] s_axi_arprot_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // AXI4-Lite read data channel
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Analog PLL status
  input wire cal_done_i,
  input wire pll_locked_i,
  // PLL and calibration control
  output wire pll_enable_o,
  output wire cal_reset_o,
  output wire cal_start_o,
  output wire outputs_enable_o,
  // Output stage control
  output reg [9:0] crystal_margin_offset_o,
  output reg first_output_tristate_o,
  output reg output_mute_o,
  output reg first_output_invert_o,
  output reg second_output_invert_o
);

  // Stored fields.
  reg pll_power_down_r;
  reg output_select_r;
  reg calibration_trigger_r;
  reg auto_lock_start_r;
  reg [1:0] margin_hi_r;
  reg [7:0] margin_lo_r;
  reg sw_rst_r;

  // Write channel state.
  reg aw_full_r;
  reg w_full_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [7:0] wbyte_r;
  reg wlane_r;

  // Sequencer status.
  wire cal_busy;
  wire halted;
  wire cal_complete;
  reg pll_locked_r;

  wire dev_rst;
  wire aw_take;
  wire w_take;
  wire do_wr;
  wire [ADDR_W-3:0] wr_idx;
  wire [ADDR_W-3:0] rd_idx;
  wire wr_device_control;
  wire wr_margin_hi;
  wire wr_margin_lo;
  wire wr_out_ctl;
  wire wr_out_pol;
  wire wr_sw_rst;
  wire wr_hit;
  wire cal_trigger_rise;
  wire auto_start_write;
  wire pdn_nxt;

  reg [7:0] rd_byte;
  reg rd_hit;

  // The reset pin is taken as synchronous; the software bit gives a one-cycle pulse.
  assign dev_rst = !reset_input_pin_n_i || sw_rst_r; // R8

  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take = s_axi_wvalid_i && s_axi_wready_o;
  assign do_wr = aw_full_r && w_full_r && !s_axi_bvalid_o;

  assign wr_idx = awaddr_r[ADDR_W-1:2];
  assign rd_idx = s_axi_araddr_i[ADDR_W-1:2];

  // Only byte lane 0 carries register bits; a write with that strobe low stores nothing.
  assign wr_device_control = do_wr && wlane_r && (wr_idx == `OSC_IDX_DEVICE_CONTROL);
  assign wr_margin_hi = do_wr && wlane_r && (wr_idx == `OSC_IDX_MARGIN_HI);
  assign wr_margin_lo = do_wr && wlane_r && (wr_idx == `OSC_IDX_MARGIN_LO);
  assign wr_out_ctl = do_wr && wlane_r && (wr_idx == `OSC_IDX_OUT_CTL);
  assign wr_out_pol = do_wr && wlane_r && (wr_idx == `OSC_IDX_OUT_POL);
  assign wr_sw_rst = do_wr && wlane_r && (wr_idx == `OSC_IDX_SW_RST);

  assign wr_hit = (wr_idx == `OSC_IDX_DEVICE_CONTROL) || (wr_idx == `OSC_IDX_MARGIN_HI) ||
                  (wr_idx == `OSC_IDX_MARGIN_LO) || (wr_idx == `OSC_IDX_OUT_CTL) ||
                  (wr_idx == `OSC_IDX_OUT_POL) || (wr_idx == `OSC_IDX_STATUS) ||
                  (wr_idx == `OSC_IDX_SW_RST);

  // Only a zero-to-one change of the stored trigger bit starts a calibration.
  assign cal_trigger_rise = wr_device_control && wbyte_r[`OSC_DC_CAL] && !calibration_trigger_r; // R4
  assign auto_start_write = wr_device_control && wbyte_r[`OSC_DC_AUTO]; // R9
  assign pdn_nxt = wr_device_control ? wbyte_r[`OSC_DC_PDN] : pll_power_down_r;

  osc_lock_seq u_seq (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .dev_rst_i(dev_rst),
    .auto_lock_start_i(auto_lock_start_r),
    .auto_start_write_i(auto_start_write),
    .pll_power_down_i(pdn_nxt),
    .cal_trigger_rise_i(cal_trigger_rise),
    .cal_done_i(cal_done_i),
    .pll_locked_i(pll_locked_i),
    .pll_enable_o(pll_enable_o),
    .cal_reset_o(cal_reset_o),
    .cal_start_o(cal_start_o),
    .cal_busy_o(cal_busy),
    .outputs_enable_o(outputs_enable_o),
    .halted_o(halted),
    .cal_complete_o(cal_complete)
  );

  // Write address and data are taken in either order and joined before the write.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `OSC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        wbyte_r <= s_axi_wdata_i[7:0];
        wlane_r <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Register storage; a device reset restores every field except auto-start to its reset value.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pll_power_down_r <= `OSC_RST_PDN;
      output_select_r <= `OSC_RST_SEL;
      calibration_trigger_r <= `OSC_RST_CAL;
      auto_lock_start_r <= `OSC_RST_AUTO;
      margin_hi_r <= `OSC_RST_MARGIN_HI;
      margin_lo_r <= `OSC_RST_MARGIN_LO;
      first_output_tristate_o <= `OSC_RST_HIZ;
      output_mute_o <= `OSC_RST_MUTE;
      first_output_invert_o <= `OSC_RST_INV;
      second_output_invert_o <= `OSC_RST_INV;
      sw_rst_r <= 1'b0;
    end else if (dev_rst) begin // R8
      // Auto-start survives a device reset, otherwise software could never choose to halt.
      pll_power_down_r <= `OSC_RST_PDN;
      output_select_r <= `OSC_RST_SEL;
      calibration_trigger_r <= `OSC_RST_CAL;
      margin_hi_r <= `OSC_RST_MARGIN_HI;
      margin_lo_r <= `OSC_RST_MARGIN_LO;
      first_output_tristate_o <= `OSC_RST_HIZ;
      output_mute_o <= `OSC_RST_MUTE;
      first_output_invert_o <= `OSC_RST_INV;
      second_output_invert_o <= `OSC_RST_INV;
      sw_rst_r <= 1'b0;
    end else begin
      sw_rst_r <= wr_sw_rst && wbyte_r[`OSC_SR_BIT]; // R8
      // Reserved bit positions are simply not stored.
      if (wr_device_control) begin // R14
        pll_power_down_r <= wbyte_r[`OSC_DC_PDN]; // R1 R2
        output_select_r <= wbyte_r[`OSC_DC_SEL];
        auto_lock_start_r <= wbyte_r[`OSC_DC_AUTO]; // R7 R9
      end
      // A new write of one wins over a completion in the same cycle.
      if (wr_device_control && wbyte_r[`OSC_DC_CAL]) begin
        calibration_trigger_r <= 1'b1; // R4
      end else if (wr_device_control || cal_complete) begin
        calibration_trigger_r <= 1'b0; // R5
      end
      if (wr_margin_hi) begin
        margin_hi_r <= wbyte_r[1:0]; // R10
      end
      if (wr_margin_lo) begin
        margin_lo_r <= wbyte_r; // R10
      end
      if (wr_out_ctl) begin
        first_output_tristate_o <= wbyte_r[`OSC_OC_HIZ]; // R11
        output_mute_o <= wbyte_r[`OSC_OC_MUTE]; // R12
      end
      if (wr_out_pol) begin
        second_output_invert_o <= wbyte_r[`OSC_OP_INV1]; // R13
        first_output_invert_o <= wbyte_r[`OSC_OP_INV0]; // R13
      end
    end
  end

  // The offset is registered once more so that the output stage sees one coherent word.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crystal_margin_offset_o <= {`OSC_RST_MARGIN_LO, `OSC_RST_MARGIN_HI};
      pll_locked_r <= 1'b0;
    end else begin
      crystal_margin_offset_o <= {margin_lo_r, margin_hi_r}; // R10
      pll_locked_r <= pll_locked_i;
    end
  end

  // Read decode; unused positions read as zero.
  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      `OSC_IDX_DEVICE_CONTROL: begin
        rd_byte[`OSC_DC_PDN] = pll_power_down_r;
        rd_byte[`OSC_DC_SEL] = output_select_r;
        rd_byte[`OSC_DC_CAL] = calibration_trigger_r;
        rd_byte[`OSC_DC_AUTO] = auto_lock_start_r;
      end
      `OSC_IDX_MARGIN_HI: begin
        rd_byte[1:0] = margin_hi_r; // R14
      end
      `OSC_IDX_MARGIN_LO: begin
        rd_byte = margin_lo_r;
      end
      `OSC_IDX_OUT_CTL: begin
        rd_byte[`OSC_OC_HIZ] = first_output_tristate_o;
        rd_byte[`OSC_OC_MUTE] = output_mute_o;
      end
      `OSC_IDX_OUT_POL: begin
        rd_byte[`OSC_OP_INV1] = second_output_invert_o;
        rd_byte[`OSC_OP_INV0] = first_output_invert_o;
      end
      `OSC_IDX_STATUS: begin
        rd_byte[`OSC_ST_PLL_EN] = pll_enable_o;
        rd_byte[`OSC_ST_CAL_BUSY] = cal_busy;
        rd_byte[`OSC_ST_LOCKED] = pll_locked_r;
        rd_byte[`OSC_ST_OUT_EN] = outputs_enable_o;
        rd_byte[`OSC_ST_HALTED] = halted;
      end
      `OSC_IDX_SW_RST: begin
        rd_byte = 8'h00;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one read outstanding, answered the cycle after the address is taken.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `OSC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h000000, rd_byte}; // R14
        s_axi_rresp_o <= rd_hit ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule

// [rtl/osc_lock_seq.v]
// PLL power, calibration and lock sequencer of the oscillator control bank.
module osc_lock_seq (
  // Clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  input wire dev_rst_i,
  // Controls from the register bank
  input wire auto_lock_start_i,
  input wire auto_start_write_i,
  input wire pll_power_down_i,
  input wire cal_trigger_rise_i,
  // Analog status
  input wire cal_done_i,
  input wire pll_locked_i,
  // Sequencer outputs
  output reg pll_enable_o,
  output reg cal_reset_o,
  output reg cal_start_o,
  output reg cal_busy_o,
  output reg outputs_enable_o,
  output reg halted_o,
  output reg cal_complete_o
);

  localparam S_CONFIG = 6'h01;
  localparam S_HALT = 6'h02;
  localparam S_CAL = 6'h04;
  localparam S_LOCK = 6'h08;
  localparam S_RUN = 6'h10;
  localparam S_PDN = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_CONFIG: begin
        // The trigger bit is not looked at here: auto-start decides the start-up path.
        if (pll_power_down_i) begin
          state_nxt = S_PDN;
        end else if (auto_lock_start_i) begin // R6 R7
          state_nxt = S_CAL; // R3
        end else begin
          state_nxt = S_HALT; // R9
        end
      end
      S_HALT: begin
        if (pll_power_down_i) begin
          state_nxt = S_PDN;
        end else if (auto_start_write_i || cal_trigger_rise_i) begin // R9 R4
          state_nxt = S_CAL;
        end
      end
      S_CAL: begin
        if (pll_power_down_i) begin
          state_nxt = S_PDN; // R1
        end else if (cal_done_i) begin
          state_nxt = S_LOCK;
        end
      end
      S_LOCK: begin
        if (pll_power_down_i) begin
          state_nxt = S_PDN; // R1
        end else if (cal_trigger_rise_i) begin
          state_nxt = S_CAL; // R4
        end else if (pll_locked_i) begin
          state_nxt = S_RUN; // R7
        end
      end
      S_RUN: begin
        if (pll_power_down_i) begin
          state_nxt = S_PDN; // R1
        end else if (cal_trigger_rise_i) begin
          state_nxt = S_CAL; // R4
        end else if (!pll_locked_i) begin
          state_nxt = S_LOCK;
        end
      end
      S_PDN: begin
        if (!pll_power_down_i) begin
          state_nxt = S_CAL; // R2
        end
      end
      default: begin
        state_nxt = S_CONFIG;
      end
    endcase
    if (dev_rst_i) begin
      state_nxt = S_CONFIG; // R8
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= S_CONFIG;
      pll_enable_o <= 1'b0;
      cal_reset_o <= 1'b1;
      cal_start_o <= 1'b0;
      cal_busy_o <= 1'b0;
      outputs_enable_o <= 1'b0;
      halted_o <= 1'b0;
      cal_complete_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // The PLL runs and calibration leaves reset only in the active states.
      pll_enable_o <= (state_nxt == S_CAL) || (state_nxt == S_LOCK) || (state_nxt == S_RUN); // R1 R2
      cal_reset_o <= !((state_nxt == S_CAL) || (state_nxt == S_LOCK) || (state_nxt == S_RUN)); // R1
      cal_start_o <= (state_nxt == S_CAL) && (state_r != S_CAL); // R4
      cal_busy_o <= (state_nxt == S_CAL);
      outputs_enable_o <= (state_nxt == S_RUN); // R7
      halted_o <= (state_nxt == S_HALT);
      cal_complete_o <= (state_r == S_CAL) && (state_nxt == S_LOCK); // R5
    end
  end

endmodule

// [verif/osc_ctrl_regs_asserts.sv]
// Bus and sequencer checks on the ports of the oscillator control bank.
module osc_ctrl_regs_chk (
  // Clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // Bus handshakes
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Sequencer outputs
  input wire pll_enable_o,
  input wire cal_reset_o,
  input wire cal_start_o,
  input wire outputs_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire wr_take = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  wire rd_take = s_axi_arvalid_i && s_axi_arready_o;
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid_o)
    else $error("write response not two cycles after take");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read response not one cycle after take");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read response dropped");
  a_reserved_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_start_pulse: assert property (cal_start_o |=> !cal_start_o)
    else $error("calibration start longer than one cycle");
  a_start_enabled: assert property (cal_start_o |-> pll_enable_o && !cal_reset_o)
    else $error("calibration started with PLL off");
  a_out_after_cal: assert property (outputs_enable_o |-> pll_enable_o && !cal_reset_o)
    else $error("outputs enabled with PLL off");
  c_write: cover property (wr_take);
  c_read: cover property (rd_take);
  c_outputs_on: cover property ($rose(outputs_enable_o));
  c_cal_start: cover property (cal_start_o);
endmodule
bind osc_ctrl_regs osc_ctrl_regs_chk u_osc_ctrl_regs_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .pll_enable_o(pll_enable_o),
  .cal_reset_o(cal_reset_o), .cal_start_o(cal_start_o),
  .outputs_enable_o(outputs_enable_o));

// [verif/osc_ctrl_regs_test.sv]
// Self-checking bench of the oscillator control bank over its register bus.
`include "osc_ctrl_map.vh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module osc_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, nrst_i = 0, rst_pin_n = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pll_en, cal_rst, cal_st, out_en;
  logic [31:0] rdata;
  logic cal_done = 0, locked = 0;
  logic [9:0] offset;
  logic tri0_o, mute_o, inv0_o, inv1_o;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [1:0] bq[$];
  logic [1:0] eb;
  logic [7:0] hi, lo;
  int num_errors = 0, check_count = 0, cycles = 0, k, starts = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  osc_ctrl_regs u_osc_ctrl_regs (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reset_input_pin_n_i(rst_pin_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .cal_done_i(cal_done), .pll_locked_i(locked),
    .pll_enable_o(pll_en), .cal_reset_o(cal_rst), .cal_start_o(cal_st),
    .outputs_enable_o(out_en), .crystal_margin_offset_o(offset),
    .first_output_tristate_o(tri0_o), .output_mute_o(mute_o),
    .first_output_invert_o(inv0_o), .second_output_invert_o(inv1_o));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cal_st === 1'b1) starts++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // Bus responses are matched in issue order, one per response handshake.
  always @(posedge sys_clk_i) begin
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      `CHK("read", e, {rresp, rdata})
    end
    if (bvalid && bready) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
  end
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    bit aw_ok = 0, w_ok = 0;
    bq.push_back(er);
    @(posedge sys_clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge sys_clk_i);
      if (awready && !aw_ok) begin aw_ok = 1; awvalid <= 0; end
      if (wready && !w_ok) begin w_ok = 1; wvalid <= 0; end
    end while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    bit ar_ok = 0;
    exp_q.push_back({er, 24'h000000, d});
    @(posedge sys_clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge sys_clk_i);
      if (arready && !ar_ok) begin ar_ok = 1; arvalid <= 0; end
    end while (!rvalid);
    rready <= 0;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic pulse_done;
    @(posedge sys_clk_i);
    cal_done <= 1;
    @(posedge sys_clk_i);
    cal_done <= 0;
  endtask
  initial begin
    void'($urandom(93));
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1;
    settle();
    `CHK("pll on after reset", 2'b10, {pll_en, cal_rst})
    rd(`OSC_IDX_DEVICE_CONTROL, 8'h21, 2'h0);
    rd(`OSC_IDX_MARGIN_HI, 8'h00, 2'h0);
    rd(`OSC_IDX_MARGIN_LO, 8'h80, 2'h0);
    rd(`OSC_IDX_OUT_CTL, 8'h00, 2'h0);
    rd(`OSC_IDX_OUT_POL, 8'h00, 2'h0);
    `CHK("offset reset", 10'h200, offset)
    $display("test reset values done");
    pulse_done();
    @(posedge sys_clk_i);
    locked <= 1;
    k = 0;
    while (out_en !== 1'b1 && k < 20) begin @(posedge sys_clk_i); k++; end
    `CHK("outputs after lock", 1'b1, out_en)
    locked <= 0;
    wr(`OSC_IDX_DEVICE_CONTROL, 8'h61, 2'h0);
    settle();
    `CHK("power down", 3'b010, {pll_en, cal_rst, out_en})
    wr(`OSC_IDX_DEVICE_CONTROL, 8'h21, 2'h0);
    settle();
    `CHK("power up", 2'b10, {pll_en, cal_rst})
    rd(`OSC_IDX_STATUS, 8'h03, 2'h0);
    pulse_done();
    $display("test power down done");
    wr(`OSC_IDX_DEVICE_CONTROL, 8'h23, 2'h0);
    rd(`OSC_IDX_STATUS, 8'h03, 2'h0);
    rd(`OSC_IDX_DEVICE_CONTROL, 8'h23, 2'h0);
    pulse_done();
    rd(`OSC_IDX_DEVICE_CONTROL, 8'h21, 2'h0);
    $display("test calibration trigger done");
    for (int i = 0; i < 4; i++) begin
      hi = $urandom();
      lo = $urandom();
      wr(`OSC_IDX_MARGIN_HI, hi, 2'h0);
      wr(`OSC_IDX_MARGIN_LO, lo, 2'h0);
      rd(`OSC_IDX_MARGIN_HI, {6'h00, hi[1:0]}, 2'h0);
      settle();
      `CHK("margin offset", {lo, hi[1:0]}, offset)
    end
    $display("test margin offset done");
    wr(`OSC_IDX_OUT_CTL, 8'hFF, 2'h0);
    wr(`OSC_IDX_OUT_POL, 8'hFF, 2'h0);
    settle();
    `CHK("outputs all set", 4'hF, {tri0_o, mute_o, inv0_o, inv1_o})
    rd(`OSC_IDX_OUT_CTL, 8'h06, 2'h0);
    rd(`OSC_IDX_OUT_POL, 8'h30, 2'h0);
    wr(`OSC_IDX_OUT_CTL, 8'h04, 2'h0);
    wr(`OSC_IDX_OUT_POL, 8'h10, 2'h0);
    settle();
    `CHK("tristate only", 2'b10, {tri0_o, mute_o})
    `CHK("invert zero only", 2'b10, {inv0_o, inv1_o})
    $display("test output controls done");
    wr(10'h3FF, 8'hFF, 2'h2);
    rd(10'h3FF, 8'h00, 2'h2);
    $display("test unmapped done");
    wr(`OSC_IDX_MARGIN_LO, 8'h55, 2'h0);
    wr(`OSC_IDX_SW_RST, 8'h01, 2'h0);
    settle();
    rd(`OSC_IDX_MARGIN_LO, 8'h80, 2'h0);
    rd(`OSC_IDX_OUT_CTL, 8'h00, 2'h0);
    wr(`OSC_IDX_OUT_POL, 8'h20, 2'h0);
    @(posedge sys_clk_i);
    rst_pin_n <= 0;
    repeat (3) @(posedge sys_clk_i);
    rst_pin_n <= 1;
    settle();
    `CHK("pin reset invert", 1'b0, inv1_o)
    rd(`OSC_IDX_DEVICE_CONTROL, 8'h21, 2'h0);
    $display("test device reset done");
    wr(`OSC_IDX_DEVICE_CONTROL, 8'h20, 2'h0);
    wr(`OSC_IDX_SW_RST, 8'h01, 2'h0);
    settle();
    rd(`OSC_IDX_STATUS, 8'h10, 2'h0);
    rd(`OSC_IDX_DEVICE_CONTROL, 8'h20, 2'h0);
    wr(`OSC_IDX_DEVICE_CONTROL, 8'h21, 2'h0);
    settle();
    rd(`OSC_IDX_STATUS, 8'h03, 2'h0);
    `CHK("calibration starts", 6, starts)
    $display("test halt and start done");
    settle();
    summarize();
  end
endmodule
